// >>> chg_defs.svh
// Purpose: register offsets, field positions and reset values of the charger flag bank
// Assumes: byte-wide registers reached through the device register read port
// Notes:   definitions only
`ifndef CHG_DEFS_SVH
`define CHG_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define CHG_ADDR_FAULT_FIRST  8'h20
`define CHG_ADDR_FAULT_SECOND 8'h21
`define CHG_ADDR_EVENT_FIRST  8'h22
`define CHG_ADDR_EVENT_SECOND 8'h23

// ----------------------------------------------------------------
// reset value, shared by every register
// ----------------------------------------------------------------
`define CHG_REG_RESET 8'h00

// ----------------------------------------------------------------
// fault status field positions
// ----------------------------------------------------------------
`define CHG_BIT_IN1_OVP    0
`define CHG_BIT_SYS_SHORT  7
`define CHG_BIT_SYS_OVP    6
`define CHG_BIT_DIE_TSHUT  2

// ----------------------------------------------------------------
// first event flag field positions
// ----------------------------------------------------------------
`define CHG_BIT_ICL_EV     7
`define CHG_BIT_IVL_EV     6
`define CHG_BIT_WDOG_EV    5
`define CHG_BIT_WEAK_EV    4
`define CHG_BIT_PGOOD_EV   3
`define CHG_BIT_IN2_EV     2
`define CHG_BIT_IN1_EV     1
`define CHG_BIT_BUSP_EV    0

// ----------------------------------------------------------------
// second event flag field positions
// ----------------------------------------------------------------
`define CHG_BIT_CHARGE_EV  7
`define CHG_BIT_ICO_EV     6
`define CHG_BIT_RSVD_HI    5
`define CHG_BIT_BUSST_EV   4
`define CHG_BIT_RSVD_LO    3
`define CHG_BIT_TREG_EV    2
`define CHG_BIT_BATT_EV    1
`define CHG_BIT_CTYPE_EV   0

`endif

// >>> chg_pkg.sv
// Purpose: shared types of the charger flag bank
// Assumes: nothing
// Notes:   constants live in chg_defs.svh
package chg_pkg;
  typedef logic [7:0] chg_byte_t;
  typedef enum logic [1:0] {
    CHG_DETECT_RISE   = 2'b01,
    CHG_DETECT_CHANGE = 2'b10
  } chg_detect_e;
endpackage

// >>> chg_event_flag.sv
// Purpose: one sticky event flag set by a rising edge or by any change of its source
// Assumes: source synchronous to clk
// Notes:   first sample after reset only primes the history, it raises no event
module chg_event_flag #(
  parameter int                  W    = 1,
  parameter chg_pkg::chg_detect_e MODE = chg_pkg::CHG_DETECT_CHANGE
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         ce,
  input  wire logic [W-1:0] src,
  input  wire logic         clr,
  output logic              flag
);
  import chg_pkg::*;

  logic [W-1:0] prev_reg;
  logic         primed_reg;
  logic         flag_reg;
  wire          hit_w;
  wire          flag_next;

  // ----------------------------------------------------------------
  // detection and sticky latch
  // ----------------------------------------------------------------
  assign hit_w = primed_reg & ((MODE == CHG_DETECT_RISE) ? |(src & ~prev_reg)
                                                         : (src != prev_reg));
  // set wins over a clear in the same cycle
  assign flag_next = hit_w | (flag_reg & ~clr);
  assign flag      = flag_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_reg   <= '0;
      primed_reg <= 1'b0;
      flag_reg   <= 1'b0;
    end else if (ce) begin
      prev_reg   <= src;
      primed_reg <= 1'b1;
      flag_reg   <= flag_next;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  flag_sticky_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && flag_reg && !clr) |=> flag_reg)
    else $error("event flag dropped without a clear");

  set_beats_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && hit_w && clr) |=> flag_reg)
    else $error("event lost against a same-cycle clear");

  clear_works_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && clr && !hit_w) |=> !flag_reg)
    else $error("cleared flag still set");

  freeze_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    !ce |=> $stable(flag_reg) && $stable(prev_reg))
    else $error("state moved while clock enable low");
endmodule

// >>> chg_fault_flags.sv
// Purpose: fault status bits and sticky event flags of a buck-boost charger, read by address
// Assumes: all inputs synchronous to MCLK; CE low freezes every flop
// Notes:   event registers clear on read; status registers follow the live conditions
`include "chg_defs.svh"

module chg_fault_flags #(
  parameter int CHG_W   = 3,
  parameter int ICO_W   = 2,
  parameter int BUSST_W = 4,
  parameter int CTYPE_W = 1
) (
  input  wire logic                MCLK,
  input  wire logic                RST_B,
  input  wire logic                CE,
  input  wire logic                INPUT1_OVERVOLTAGE_STATUS,
  input  wire logic                SYSTEM_RAIL_SHORT_STATUS,
  input  wire logic                SYSTEM_RAIL_OVERVOLTAGE_STATUS,
  input  wire logic                DIE_THERMAL_SHUTDOWN_STATUS,
  input  wire logic                INPUT_CURRENT_LIMIT,
  input  wire logic                INPUT_VOLTAGE_LIMIT,
  input  wire logic                WATCHDOG_EXPIRED,
  input  wire logic                WEAK_SOURCE,
  input  wire logic                POWER_GOOD_STATUS,
  input  wire logic                INPUT2_PRESENT,
  input  wire logic                INPUT1_PRESENT,
  input  wire logic                BUS_PRESENT,
  input  wire logic [CHG_W-1:0]    CHARGE_STATE,
  input  wire logic [ICO_W-1:0]    CURRENT_OPTIMIZER_STATE,
  input  wire logic [BUSST_W-1:0]  BUS_STATE,
  input  wire logic                THERMAL_REGULATION,
  input  wire logic                BATTERY_PRESENT,
  input  wire logic [CTYPE_W-1:0]  CHARGER_TYPE_STATE,
  input  wire logic                RD_EN,
  input  wire logic [7:0]          RD_ADDR,
  output chg_pkg::chg_byte_t       RD_DATA,
  output logic                     RD_VALID
);
  import chg_pkg::*;

  chg_byte_t fault_first_reg;
  chg_byte_t fault_second_reg;
  chg_byte_t rd_data_reg;
  logic      rd_valid_reg;
  chg_byte_t ev1_w;
  chg_byte_t ev2_w;
  chg_byte_t fault_first_next;
  chg_byte_t fault_second_next;
  chg_byte_t rd_mux_w;
  wire       clr_ev1_w;
  wire       clr_ev2_w;

  // ----------------------------------------------------------------
  // live fault status, reserved positions stay zero
  // ----------------------------------------------------------------
  assign fault_first_next  = chg_byte_t'(INPUT1_OVERVOLTAGE_STATUS) << `CHG_BIT_IN1_OVP;
  assign fault_second_next =
      (chg_byte_t'(SYSTEM_RAIL_SHORT_STATUS)       << `CHG_BIT_SYS_SHORT)
    | (chg_byte_t'(SYSTEM_RAIL_OVERVOLTAGE_STATUS) << `CHG_BIT_SYS_OVP)
    | (chg_byte_t'(DIE_THERMAL_SHUTDOWN_STATUS)    << `CHG_BIT_DIE_TSHUT);

  // ----------------------------------------------------------------
  // read decode; a read of an event register clears it
  // ----------------------------------------------------------------
  assign clr_ev1_w = RD_EN && (RD_ADDR == `CHG_ADDR_EVENT_FIRST);
  assign clr_ev2_w = RD_EN && (RD_ADDR == `CHG_ADDR_EVENT_SECOND);
  // unmapped offsets read as zero; no write path exists at all
  assign rd_mux_w =
    (RD_ADDR == `CHG_ADDR_FAULT_FIRST)  ? fault_first_reg  :
    (RD_ADDR == `CHG_ADDR_FAULT_SECOND) ? fault_second_reg :
    (RD_ADDR == `CHG_ADDR_EVENT_FIRST)  ? ev1_w            :
    (RD_ADDR == `CHG_ADDR_EVENT_SECOND) ? ev2_w            : `CHG_REG_RESET;
  assign ev2_w[`CHG_BIT_RSVD_HI] = 1'b0;
  assign ev2_w[`CHG_BIT_RSVD_LO] = 1'b0;

  assign RD_DATA  = rd_data_reg;
  assign RD_VALID = rd_valid_reg;

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      fault_first_reg  <= `CHG_REG_RESET;
      fault_second_reg <= `CHG_REG_RESET;
      rd_data_reg      <= `CHG_REG_RESET;
      rd_valid_reg     <= 1'b0;
    end else if (CE) begin
      fault_first_reg  <= fault_first_next;
      fault_second_reg <= fault_second_next;
      rd_valid_reg     <= RD_EN;
      if (RD_EN) begin
        rd_data_reg <= rd_mux_w;
      end
    end
  end

  // ----------------------------------------------------------------
  // first event register
  // ----------------------------------------------------------------
  chg_event_flag #(.W(1), .MODE(CHG_DETECT_RISE)) u_icl (
    .clk(MCLK), .rst_b(RST_B), .ce(CE), .src(INPUT_CURRENT_LIMIT),
    .clr(clr_ev1_w), .flag(ev1_w[`CHG_BIT_ICL_EV]));
  chg_event_flag #(.W(1), .MODE(CHG_DETECT_RISE)) u_ivl (
    .clk(MCLK), .rst_b(RST_B), .ce(CE), .src(INPUT_VOLTAGE_LIMIT),
    .clr(clr_ev1_w), .flag(ev1_w[`CHG_BIT_IVL_EV]));
  chg_event_flag #(.W(1), .MODE(CHG_DETECT_RISE)) u_wdog (
    .clk(MCLK), .rst_b(RST_B), .ce(CE), .src(WATCHDOG_EXPIRED),
    .clr(clr_ev1_w), .flag(ev1_w[`CHG_BIT_WDOG_EV]));
  chg_event_flag #(.W(1), .MODE(CHG_DETECT_RISE)) u_weak (
    .clk(MCLK), .rst_b(RST_B), .ce(CE), .src(WEAK_SOURCE),
    .clr(clr_ev1_w), .flag(ev1_w[`CHG_BIT_WEAK_EV]));
  chg_event_flag #(.W(1), .MODE(CHG_DETECT_CHANGE)) u_pgood (
    .clk(MCLK), .rst_b(RST_B), .ce(CE), .src(POWER_GOOD_STATUS),
    .clr(clr_ev1_w), .flag(ev1_w[`CHG_BIT_PGOOD_EV]));
  chg_event_flag #(.W(1), .MODE(CHG_DETECT_CHANGE)) u_in2 (
    .clk(MCLK), .rst_b(RST_B), .ce(CE), .src(INPUT2_PRESENT),
    .clr(clr_ev1_w), .flag(ev1_w[`CHG_BIT_IN2_EV]));
  chg_event_flag #(.W(1), .MODE(CHG_DETECT_CHANGE)) u_in1 (
    .clk(MCLK), .rst_b(RST_B), .ce(CE), .src(INPUT1_PRESENT),
    .clr(clr_ev1_w), .flag(ev1_w[`CHG_BIT_IN1_EV]));
  chg_event_flag #(.W(1), .MODE(CHG_DETECT_CHANGE)) u_busp (
    .clk(MCLK), .rst_b(RST_B), .ce(CE), .src(BUS_PRESENT),
    .clr(clr_ev1_w), .flag(ev1_w[`CHG_BIT_BUSP_EV]));

  // ----------------------------------------------------------------
  // second event register
  // ----------------------------------------------------------------
  chg_event_flag #(.W(CHG_W), .MODE(CHG_DETECT_CHANGE)) u_charge (
    .clk(MCLK), .rst_b(RST_B), .ce(CE), .src(CHARGE_STATE),
    .clr(clr_ev2_w), .flag(ev2_w[`CHG_BIT_CHARGE_EV]));
  chg_event_flag #(.W(ICO_W), .MODE(CHG_DETECT_CHANGE)) u_ico (
    .clk(MCLK), .rst_b(RST_B), .ce(CE), .src(CURRENT_OPTIMIZER_STATE),
    .clr(clr_ev2_w), .flag(ev2_w[`CHG_BIT_ICO_EV]));
  chg_event_flag #(.W(BUSST_W), .MODE(CHG_DETECT_CHANGE)) u_busst (
    .clk(MCLK), .rst_b(RST_B), .ce(CE), .src(BUS_STATE),
    .clr(clr_ev2_w), .flag(ev2_w[`CHG_BIT_BUSST_EV]));
  chg_event_flag #(.W(1), .MODE(CHG_DETECT_RISE)) u_treg (
    .clk(MCLK), .rst_b(RST_B), .ce(CE), .src(THERMAL_REGULATION),
    .clr(clr_ev2_w), .flag(ev2_w[`CHG_BIT_TREG_EV]));
  chg_event_flag #(.W(1), .MODE(CHG_DETECT_CHANGE)) u_batt (
    .clk(MCLK), .rst_b(RST_B), .ce(CE), .src(BATTERY_PRESENT),
    .clr(clr_ev2_w), .flag(ev2_w[`CHG_BIT_BATT_EV]));
  chg_event_flag #(.W(CTYPE_W), .MODE(CHG_DETECT_CHANGE)) u_ctype (
    .clk(MCLK), .rst_b(RST_B), .ce(CE), .src(CHARGER_TYPE_STATE),
    .clr(clr_ev2_w), .flag(ev2_w[`CHG_BIT_CTYPE_EV]));

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  in1_ovp_read_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    (CE && $past(CE) && $past(RST_B) && RD_EN && RD_ADDR == `CHG_ADDR_FAULT_FIRST)
    |=> RD_VALID && RD_DATA[`CHG_BIT_IN1_OVP] == $past(INPUT1_OVERVOLTAGE_STATUS, 2))
    else $error("input 1 overvoltage bit does not follow its condition");

  sys_short_read_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    (CE && $past(CE) && $past(RST_B) && RD_EN && RD_ADDR == `CHG_ADDR_FAULT_SECOND)
    |=> RD_DATA[`CHG_BIT_SYS_SHORT] == $past(SYSTEM_RAIL_SHORT_STATUS, 2))
    else $error("system short bit does not follow its condition");

  sys_ovp_read_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    (CE && $past(CE) && $past(RST_B) && RD_EN && RD_ADDR == `CHG_ADDR_FAULT_SECOND)
    |=> RD_DATA[`CHG_BIT_SYS_OVP] == $past(SYSTEM_RAIL_OVERVOLTAGE_STATUS, 2))
    else $error("system overvoltage bit does not follow its condition");

  die_tshut_read_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    (CE && $past(CE) && $past(RST_B) && RD_EN && RD_ADDR == `CHG_ADDR_FAULT_SECOND)
    |=> RD_DATA[`CHG_BIT_DIE_TSHUT] == $past(DIE_THERMAL_SHUTDOWN_STATUS, 2))
    else $error("thermal shutdown bit does not follow its condition");

  unmapped_zero_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    (CE && RD_EN && (RD_ADDR < `CHG_ADDR_FAULT_FIRST || RD_ADDR > `CHG_ADDR_EVENT_SECOND))
    |=> RD_VALID && RD_DATA == `CHG_REG_RESET)
    else $error("unmapped offset read non-zero");

  icl_rise_sets_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    (CE && $past(CE) && $past(RST_B) && INPUT_CURRENT_LIMIT && !$past(INPUT_CURRENT_LIMIT))
    |=> ev1_w[`CHG_BIT_ICL_EV])
    else $error("current limit rising edge not flagged");

  pgood_fall_sets_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    (CE && $past(CE) && $past(RST_B) && !POWER_GOOD_STATUS && $past(POWER_GOOD_STATUS))
    |=> ev1_w[`CHG_BIT_PGOOD_EV])
    else $error("power good falling change not flagged");

  charge_change_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    (CE && $past(CE) && $past(RST_B) && CHARGE_STATE != $past(CHARGE_STATE))
    |=> ev2_w[`CHG_BIT_CHARGE_EV])
    else $error("charge state change not flagged");

  treg_fall_quiet_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    (CE && $past(CE) && !ev2_w[`CHG_BIT_TREG_EV] && !THERMAL_REGULATION)
    |=> !ev2_w[`CHG_BIT_TREG_EV])
    else $error("thermal regulation flag set without a rising edge");

  read_clears_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    (CE && $past(CE) && clr_ev1_w && ev1_w[`CHG_BIT_WDOG_EV] && !WATCHDOG_EXPIRED)
    |=> RD_DATA[`CHG_BIT_WDOG_EV] && !ev1_w[`CHG_BIT_WDOG_EV])
    else $error("read did not report then clear the watchdog flag");

  reserved_zero_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    (CE && RD_EN && RD_ADDR == `CHG_ADDR_EVENT_SECOND)
    |=> !RD_DATA[`CHG_BIT_RSVD_HI] && !RD_DATA[`CHG_BIT_RSVD_LO])
    else $error("reserved event bits read non-zero");

  fault_rsvd_zero_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    (CE && RD_EN && RD_ADDR == `CHG_ADDR_FAULT_SECOND) |=> RD_DATA[5:3] == 3'h0
    && RD_DATA[1:0] == 2'h0)
    else $error("reserved fault bits read non-zero");

  ivl_rise_sets_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    (CE && $past(CE) && $past(RST_B) && INPUT_VOLTAGE_LIMIT && !$past(INPUT_VOLTAGE_LIMIT))
    |=> ev1_w[`CHG_BIT_IVL_EV])
    else $error("voltage limit rising edge not flagged");

  wdog_rise_sets_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    (CE && $past(CE) && $past(RST_B) && WATCHDOG_EXPIRED && !$past(WATCHDOG_EXPIRED))
    |=> ev1_w[`CHG_BIT_WDOG_EV])
    else $error("watchdog rising edge not flagged");

  weak_rise_sets_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    (CE && $past(CE) && $past(RST_B) && WEAK_SOURCE && !$past(WEAK_SOURCE))
    |=> ev1_w[`CHG_BIT_WEAK_EV])
    else $error("weak source rising edge not flagged");

  pgood_rise_sets_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    (CE && $past(CE) && $past(RST_B) && POWER_GOOD_STATUS && !$past(POWER_GOOD_STATUS))
    |=> ev1_w[`CHG_BIT_PGOOD_EV])
    else $error("power good rising change not flagged");

  in2_change_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    (CE && $past(CE) && $past(RST_B) && INPUT2_PRESENT != $past(INPUT2_PRESENT))
    |=> ev1_w[`CHG_BIT_IN2_EV])
    else $error("input 2 presence change not flagged");

  in1_change_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    (CE && $past(CE) && $past(RST_B) && INPUT1_PRESENT != $past(INPUT1_PRESENT))
    |=> ev1_w[`CHG_BIT_IN1_EV])
    else $error("input 1 presence change not flagged");

  busp_change_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    (CE && $past(CE) && $past(RST_B) && BUS_PRESENT != $past(BUS_PRESENT))
    |=> ev1_w[`CHG_BIT_BUSP_EV])
    else $error("bus presence change not flagged");

  ico_change_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    (CE && $past(CE) && $past(RST_B)
     && CURRENT_OPTIMIZER_STATE != $past(CURRENT_OPTIMIZER_STATE))
    |=> ev2_w[`CHG_BIT_ICO_EV])
    else $error("current optimizer change not flagged");

  busst_change_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    (CE && $past(CE) && $past(RST_B) && BUS_STATE != $past(BUS_STATE))
    |=> ev2_w[`CHG_BIT_BUSST_EV])
    else $error("bus state change not flagged");

  treg_rise_sets_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    (CE && $past(CE) && $past(RST_B) && THERMAL_REGULATION && !$past(THERMAL_REGULATION))
    |=> ev2_w[`CHG_BIT_TREG_EV])
    else $error("thermal regulation rising edge not flagged");

  batt_change_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    (CE && $past(CE) && $past(RST_B) && BATTERY_PRESENT != $past(BATTERY_PRESENT))
    |=> ev2_w[`CHG_BIT_BATT_EV])
    else $error("battery presence change not flagged");

  ctype_change_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    (CE && $past(CE) && $past(RST_B) && CHARGER_TYPE_STATE != $past(CHARGER_TYPE_STATE))
    |=> ev2_w[`CHG_BIT_CTYPE_EV])
    else $error("charger type change not flagged");

  flag_held_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    (CE && !clr_ev2_w && ev2_w[`CHG_BIT_CHARGE_EV])
    |=> ev2_w[`CHG_BIT_CHARGE_EV])
    else $error("charge state flag dropped without a read");

  fault_first_rsvd_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    (CE && RD_EN && RD_ADDR == `CHG_ADDR_FAULT_FIRST)
    |=> RD_DATA[7:1] == 7'h00)
    else $error("reserved first fault bits read non-zero");

  valid_pulse_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    (CE && !RD_EN)
    |=> !RD_VALID)
    else $error("read valid without a taken read");

  frozen_outputs_a: assert property (@(posedge MCLK) disable iff (!RST_B)
    !CE
    |=> $stable(RD_DATA) && $stable(RD_VALID) && $stable(fault_second_reg))
    else $error("read port or fault state moved while clock enable low");
endmodule

// >>> chg_host_model.sv
// Purpose: host side of the register read port, issuing reads and collecting answers
// Assumes: design answers one clock after a taken read
// Notes:   a read that gets no answer within a few cycles reports failure to the caller
module chg_host_model (
  input  wire logic                mclk,
  output logic                     rd_en,
  output logic [7:0]               rd_addr,
  input  wire chg_pkg::chg_byte_t  rd_data,
  input  wire logic                rd_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  import chg_pkg::*;

  initial begin
    rd_en   = 1'b0;
    rd_addr = 8'h00;
  end

  // ----------------------------------------------------------------
  // one read: single-cycle request, bounded wait for the answer
  // ----------------------------------------------------------------
  task automatic read(input logic [7:0] a, output chg_byte_t d, output bit ok);
    int n;
    ok = 1'b0;
    d  = 8'h00;
    @(posedge mclk);
    rd_en   <= 1'b1;
    rd_addr <= a;
    @(posedge mclk);
    rd_en   <= 1'b0;
    for (n = 0; n < 4 && !ok; n++) begin
      #1;
      if (rd_valid === 1'b1) begin
        d  = rd_data;
        ok = 1'b1;
      end else begin
        @(posedge mclk);
      end
    end
    // address released: idle value differs from the last one
    @(posedge mclk);
    rd_addr <= ~a;
  endtask
endmodule

// >>> tb.sv
// Purpose: self-checking bench of the charger fault status and event flag bank
// Assumes: defaults of the state widths (3/2/4/1)
// Notes:   sources change at the rising edge; reads go through the host model
`include "chg_defs.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import chg_pkg::*;

  logic       MCLK, RST_B, CE, RD_EN, RD_VALID;
  logic [7:0] RD_ADDR;
  chg_byte_t  RD_DATA;
  logic [3:0] flt;
  logic [13:0] ev;
  logic [2:0] chg_st;
  logic [1:0] ico_st;
  logic [3:0] bus_st;
  logic [0:0] ct_st;
  int         errors, samples_checked;

  localparam logic [7:0] EV_MASK [14] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02,
                                          8'h01, 8'h80, 8'h40, 8'h10, 8'h04, 8'h02, 8'h01};
  localparam logic [7:0] FLT_ADDR [4] = '{8'h20, 8'h21, 8'h21, 8'h21};
  localparam logic [7:0] FLT_MASK [4] = '{8'h01, 8'h80, 8'h40, 8'h04};

  chg_fault_flags i_chg_fault_flags (
    .MCLK(MCLK), .RST_B(RST_B), .CE(CE),
    .INPUT1_OVERVOLTAGE_STATUS(flt[0]), .SYSTEM_RAIL_SHORT_STATUS(flt[1]),
    .SYSTEM_RAIL_OVERVOLTAGE_STATUS(flt[2]), .DIE_THERMAL_SHUTDOWN_STATUS(flt[3]),
    .INPUT_CURRENT_LIMIT(ev[0]), .INPUT_VOLTAGE_LIMIT(ev[1]), .WATCHDOG_EXPIRED(ev[2]),
    .WEAK_SOURCE(ev[3]), .POWER_GOOD_STATUS(ev[4]), .INPUT2_PRESENT(ev[5]),
    .INPUT1_PRESENT(ev[6]), .BUS_PRESENT(ev[7]), .CHARGE_STATE(chg_st),
    .CURRENT_OPTIMIZER_STATE(ico_st), .BUS_STATE(bus_st), .THERMAL_REGULATION(ev[11]),
    .BATTERY_PRESENT(ev[12]), .CHARGER_TYPE_STATE(ct_st),
    .RD_EN(RD_EN), .RD_ADDR(RD_ADDR), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID)
  );

  chg_host_model i_chg_host_model (
    .mclk(MCLK), .rd_en(RD_EN), .rd_addr(RD_ADDR), .rd_data(RD_DATA), .rd_valid(RD_VALID)
  );

  initial begin
    MCLK = 1'b0;
    forever #10 MCLK = ~MCLK;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic results();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge MCLK);
  endtask

  task automatic rd_chk(input logic [7:0] a, input chg_byte_t exp);
    chg_byte_t d;
    bit        ok;
    i_chg_host_model.read(a, d, ok);
    samples_checked++;
    if (!ok || d !== exp) begin
      errors++;
      $display("mismatch at %0t: addr %h got %h expected %h", $time, a, d, exp);
      if (!ok) results();
    end
  endtask

  function automatic logic [7:0] ev_addr(input int i);
    return (i < 8) ? `CHG_ADDR_EVENT_FIRST : `CHG_ADDR_EVENT_SECOND;
  endfunction

  // state fields, the 1-bit charger type too, step up or down by one; other single bits follow up
  task automatic toggle(input int i, input bit up);
    @(posedge MCLK);
    case (i)
      8:  chg_st <= up ? chg_st + 3'd1 : chg_st - 3'd1;
      9:  ico_st <= up ? ico_st + 2'd1 : ico_st - 2'd1;
      10: bus_st <= up ? bus_st + 4'd1 : bus_st - 4'd1;
      13: ct_st  <= up ? ct_st + 1'b1 : ct_st - 1'b1;
      default: ev[i] <= up;
    endcase
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values();
    rd_chk(`CHG_ADDR_FAULT_FIRST, 8'h00);
    rd_chk(`CHG_ADDR_FAULT_SECOND, 8'h00);
    rd_chk(`CHG_ADDR_EVENT_FIRST, 8'h00);
    rd_chk(`CHG_ADDR_EVENT_SECOND, 8'h00);
    rd_chk(8'h24, 8'h00);
  endtask

  task automatic t_fault_live();
    for (int i = 0; i < 4; i++) begin
      @(posedge MCLK);
      flt[i] <= 1'b1;
      cyc(2);
      rd_chk(FLT_ADDR[i], FLT_MASK[i]);
      rd_chk(FLT_ADDR[i], FLT_MASK[i]);
      @(posedge MCLK);
      flt[i] <= 1'b0;
      cyc(2);
      rd_chk(FLT_ADDR[i], 8'h00);
    end
    @(posedge MCLK);
    flt <= 4'hF;
    cyc(2);
    rd_chk(`CHG_ADDR_FAULT_SECOND, 8'hC4);
    rd_chk(`CHG_ADDR_FAULT_FIRST, 8'h01);
    @(posedge MCLK);
    flt <= 4'h0;
  endtask

  task automatic t_rise_events();
    for (int i = 0; i < 14; i++) begin
      if (i < 4 || i == 11) begin
        toggle(i, 1'b1);
        cyc(2);
        toggle(i, 1'b0);
        cyc(2);
        rd_chk(ev_addr(i), EV_MASK[i]);
        rd_chk(ev_addr(i), 8'h00);
        toggle(i, 1'b1);
        cyc(2);
        rd_chk(ev_addr(i), EV_MASK[i]);
        toggle(i, 1'b0);
        cyc(2);
        rd_chk(ev_addr(i), 8'h00);
      end
    end
  endtask

  task automatic t_change_events();
    for (int i = 4; i < 14; i++) begin
      if (i != 11) begin
        for (int d = 1; d >= 0; d--) begin
          toggle(i, d[0]);
          cyc(2);
          rd_chk(ev_addr(i), EV_MASK[i]);
          rd_chk(ev_addr(i), 8'h00);
        end
      end
    end
  endtask

  // event landing on the clearing read edge survives that read
  task automatic t_set_wins();
    chg_byte_t d;
    bit        ok;
    fork
      i_chg_host_model.read(`CHG_ADDR_EVENT_FIRST, d, ok);
      toggle(7, 1'b1);
    join
    samples_checked++;
    if (!ok || d !== 8'h00) begin
      errors++;
      $display("mismatch at %0t: same-edge read got %h expected %h", $time, d, 8'h00);
      if (!ok) results();
    end
    rd_chk(`CHG_ADDR_EVENT_FIRST, 8'h01);
    toggle(7, 1'b0);
    cyc(2);
    rd_chk(`CHG_ADDR_EVENT_FIRST, 8'h01);
  endtask

  // changes while frozen count only as the net difference on wake-up
  task automatic t_freeze();
    @(posedge MCLK);
    CE    <= 1'b0;
    ev[5] <= 1'b1;
    ev[6] <= 1'b1;
    cyc(2);
    ev[6] <= 1'b0;
    cyc(2);
    CE <= 1'b1;
    cyc(2);
    rd_chk(`CHG_ADDR_EVENT_FIRST, 8'h04);
  endtask

  // reset clears a set flag; inputs already active at release raise nothing
  task automatic t_reset_prime();
    toggle(7, 1'b1);
    cyc(2);
    RST_B  <= 1'b0;
    ev[11] <= 1'b1;
    chg_st <= 3'd5;
    cyc(3);
    RST_B <= 1'b1;
    cyc(2);
    rd_chk(`CHG_ADDR_EVENT_FIRST, 8'h00);
    rd_chk(`CHG_ADDR_EVENT_SECOND, 8'h00);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    errors = 0;
    samples_checked = 0;
    RST_B = 1'b0;
    CE = 1'b1;
    flt = 4'h0;
    ev = 14'h0000;
    chg_st = 3'd0;
    ico_st = 2'd0;
    bus_st = 4'h0;
    ct_st = 1'b0;
    cyc(5);
    RST_B <= 1'b1;
    cyc(2);
    t_reset_values();
    t_fault_live();
    t_rise_events();
    t_change_events();
    t_set_wins();
    t_freeze();
    t_reset_prime();
    results();
  end
endmodule
